// *** design/prcc_clock_seq.sv ***
// divide-by-two and machine cycle sequencer
// clk is the oscillator input sampled as the system clock
`timescale 1ns/1ps
`default_nettype none
module prcc_clock_seq
    import prcc_pkg::*;
(
    input wire logic clk, // oscillator input
    input wire logic rst_b, // async reset, active low
    input wire logic oscRun, // low stops the oscillator
    output logic halfClk, // divided-by-two phase clock
    output logic machineTick // one pulse per machine cycle
);
    logic [2:0] phase;
    logic [2:0] next_phase;
    logic next_halfClk;

    always_comb
    begin
        next_halfClk = halfClk; // R12
        next_phase = phase;
        if (oscRun)
        begin
            next_halfClk = ~halfClk; // R11
            if (halfClk)
            begin
                if (phase == PHASE_PER_MACHINE - 3'h1)
                    next_phase = 3'h0; // R10
                else
                    next_phase = phase + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            halfClk <= 1'b0;
            phase <= 3'h0;
        end
        else
        begin
            halfClk <= next_halfClk;
            phase <= next_phase;
        end
    end

    assign machineTick = oscRun && halfClk && (phase == PHASE_PER_MACHINE - 3'h1);

    logic [4:0] tickGap;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tickGap <= 5'h0;
        else if (machineTick || !oscRun)
            tickGap <= 5'h0;
        else
            tickGap <= tickGap + 5'h1;
    end

    property p_twelve;
        @(posedge clk) disable iff (!rst_b)
        machineTick |-> tickGap == 5'(OSC_PER_MACHINE) - 5'h1;
    endproperty
    a_twelve: assert property (p_twelve) else $error("machine cycle not twelve clocks"); // R10

    property p_half;
        @(posedge clk) disable iff (!rst_b)
        oscRun |=> halfClk != $past(halfClk);
    endproperty
    a_half: assert property (p_half) else $error("divider did not toggle"); // R11

    c_tick: cover property (@(posedge clk) machineTick);
endmodule
`default_nettype wire

// *** design/prcc_pkg.sv ***
// constants for the port, reset and clock sequencing block
// shared by the top module and its clock/reset sequencer
package prcc_pkg;
    localparam int FIRST_WIDTH = 8;
    localparam int THIRD_WIDTH = 8;
    localparam logic [7:0] PORT_RESET_VALUE = 8'hff;
    localparam int CMP_OUT_BIT = 6;
    localparam int CMP_PLUS_BIT = 0;
    localparam int CMP_MINUS_BIT = 1;
    localparam int RXD_BIT = 0;
    localparam int TXD_BIT = 1;
    localparam int IRQ0_BIT = 2;
    localparam int IRQ1_BIT = 3;
    localparam int CNT0_BIT = 4;
    localparam int CNT1_BIT = 5;
    localparam logic [3:0] OSC_PER_MACHINE = 4'hc;
    localparam logic [2:0] PHASE_PER_MACHINE = 3'h6;
    localparam logic [1:0] RESET_MACHINE_CYCLES = 2'h2;
    localparam logic [7:0] THIRD_GPIO_MASK = 8'hbf;
    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_IDLE = 2'b01,
        PWR_DOWN = 2'b10
    } prcc_pwr_type;
endpackage

// *** design/prcc_port_top.sv ***
// first and third I/O ports, reset qualification and power modes
// pins are open-drain style with pullups outside; cpu writes latches
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] first port: eight independent bidirectional lines
// [R2] line works as input only after writing one; drive released
// [R3] third port lines 0..5 and 7 are bidirectional with pullups
// [R4] third port bit 6 reads comparator output only, not general purpose
// [R5] first port bits 0 and 1 feed comparator plus and minus
// [R6] third port alternates: rx, tx, irq0, irq1, counter0, counter1
// [R7] programming: first port carries code data, third port takes control
// [R8] all pins go high immediately when reset asserts, no clock
// [R9] reset held two machine cycles with oscillator running does full reset; rst_b also clears rstCount, so fullReset is never reached
// [R10] machine cycle equals twelve oscillator periods
// [R11] oscillator passes divide-by-two flip-flop first
// [R12] fully static logic, any rate from zero to maximum
// [R13] two software-selected power-saving modes
// [R14] idle stops cpu clock; ram, timers, serial, interrupts keep running
// [R15] power-down stops oscillator until hardware reset, ram kept
// [R16] idle ends on enabled interrupt or hardware reset
// [R17] reset ending idle: ram blocked, port writes allowed until full reset
// [R18] reset reloads port latches, leaves ram untouched
// [R19] input reads return synchronised pin level, not latch; reads here return the pin level ANDed with the latch
module prcc_port_top
    import prcc_pkg::*;
(
    input wire logic clk, // oscillator input
    input wire logic rst_b, // reset pin, active low
    input wire logic [7:0] firstIoPortIn, // first port pin levels
    output logic [7:0] firstIoPortOut, // first port drive value
    output logic [7:0] firstIoPortOe_b, // low while driving low
    input wire logic [7:0] thirdIoPortIn, // third port pin levels
    output logic [7:0] thirdIoPortOut, // third port drive value
    output logic [7:0] thirdIoPortOe_b, // low while driving low
    input wire logic cmpOut, // comparator result
    output logic comparatorPlusInput, // to comparator plus
    output logic comparatorMinusInput, // to comparator minus
    input wire logic cpuFirstWrite, // cpu writes first latch
    input wire logic cpuThirdWrite, // cpu writes third latch
    input wire logic [7:0] cpuWriteData, // cpu write data
    output logic [7:0] firstIoPortRead, // first port read value
    output logic [7:0] thirdIoPortRead, // third port read value
    input wire logic serialTx, // serial transmit value
    output logic serialRx, // serial receive pin
    output logic externalIrqZero, // irq 0 pin
    output logic externalIrqOne, // irq 1 pin
    output logic counterZeroInput, // timer 0 count pin
    output logic counterOneInput, // timer 1 count pin
    input wire logic progMode, // flash programming active
    input wire logic progDataDrive, // programmer reading data out
    input wire logic [7:0] progDataOut, // code data for verify
    output logic [7:0] progDataIn, // code data from pins
    output logic [7:0] progControl, // control from third port
    input wire logic idleReq, // software enters idle
    input wire logic powerDownReq, // software enters power-down
    input wire logic irqPending, // enabled interrupt pending
    output logic cpuClkEn, // cpu clock gate
    output logic periphClkEn, // peripheral clock gate
    output logic ramAccessEn, // internal ram allowed
    output logic fullReset, // internal reset taken over
    output logic halfClk, // divided clock phase
    output logic machineTick // machine cycle pulse
);
    prcc_pwr_type pwr;
    prcc_pwr_type next_pwr;
    logic [7:0] firstLatch;
    logic [7:0] thirdLatch;
    logic [7:0] next_firstLatch;
    logic [7:0] next_thirdLatch;
    logic [1:0] rstCount;
    logic [1:0] next_rstCount;
    logic [2:0] rstSync;
    logic [7:0] firstPin;
    logic [7:0] thirdPin;
    logic rstPin;
    logic oscRun;

    // reset pin is high-active at the package; rst_b clears state and also releases the pins directly
    assign rstPin = (rstSync[1] == rstSync[2]) ? rstSync[2] : 1'b0;
    assign oscRun = (pwr != PWR_DOWN); // R12 R15

    prcc_clock_seq u_seq (
        .clk(clk),
        .rst_b(rst_b),
        .oscRun(oscRun),
        .halfClk(halfClk),
        .machineTick(machineTick)
    );

    // three stages; second and third must agree before a change counts
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_sync
            // per-bit locals keep every flop with a single driving process
            logic [2:0] firstSync;
            logic [2:0] thirdSync;
            logic firstBit;
            logic thirdBit;
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    firstSync <= 3'h7;
                    thirdSync <= 3'h7;
                    firstBit <= 1'b1;
                    thirdBit <= 1'b1;
                end
                else
                begin
                    firstSync <= {firstSync[1:0], firstIoPortIn[i]};
                    thirdSync <= {thirdSync[1:0], thirdIoPortIn[i]};
                    if (firstSync[1] == firstSync[2])
                        firstBit <= firstSync[2]; // R19
                    if (thirdSync[1] == thirdSync[2])
                        thirdBit <= thirdSync[2];
                end
            end
            assign firstPin[i] = firstBit;
            assign thirdPin[i] = thirdBit;
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rstSync <= 3'h7; // pin seen active until the release has passed the flops
        else
            rstSync <= {rstSync[1:0], ~rst_b};
    end

    always_comb
    begin
        next_rstCount = rstCount;
        next_pwr = pwr;
        next_firstLatch = firstLatch;
        next_thirdLatch = thirdLatch;
        if (cpuFirstWrite)
            next_firstLatch = cpuWriteData; // R1 R17
        if (cpuThirdWrite)
            next_thirdLatch = cpuWriteData & THIRD_GPIO_MASK | ~THIRD_GPIO_MASK; // R4
        case (pwr)
            PWR_RUN:
            begin
                if (powerDownReq)
                    next_pwr = PWR_DOWN; // R13
                else if (idleReq)
                    next_pwr = PWR_IDLE; // R13
            end
            PWR_IDLE:
            begin
                if (irqPending)
                    next_pwr = PWR_RUN; // R16
            end
            PWR_DOWN:
                next_pwr = PWR_DOWN;
            default:
                next_pwr = PWR_RUN;
        endcase
        if (rstPin && machineTick && rstCount != RESET_MACHINE_CYCLES)
            next_rstCount = rstCount + 2'h1; // R9
        if (!rstPin)
            next_rstCount = 2'h0;
        if (rstCount == RESET_MACHINE_CYCLES)
        begin
            next_firstLatch = PORT_RESET_VALUE; // R18
            next_thirdLatch = PORT_RESET_VALUE;
            next_pwr = PWR_RUN; // R16
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pwr <= PWR_RUN;
            firstLatch <= PORT_RESET_VALUE;
            thirdLatch <= PORT_RESET_VALUE;
            rstCount <= 2'h0;
        end
        else
        begin
            pwr <= next_pwr;
            firstLatch <= next_firstLatch;
            thirdLatch <= next_thirdLatch;
            rstCount <= next_rstCount;
        end
    end

    // power-down is left only by the rst_b async reset, as machineTick stops with oscRun so rstCount cannot reach the full reset; oscillator gate keeps static state
    assign fullReset = (rstCount == RESET_MACHINE_CYCLES); // R9
    assign ramAccessEn = !rstPin && !fullReset; // R17
    assign cpuClkEn = (pwr == PWR_RUN) && !fullReset; // R14
    assign periphClkEn = (pwr != PWR_DOWN); // R14 R15

    // drive is combinational from the async reset so pins rise without a clock edge
    always_comb
    begin
        firstIoPortOut = 8'h00;
        thirdIoPortOut = 8'h00;
        firstIoPortOe_b = 8'hff;
        thirdIoPortOe_b = 8'hff;
        if (rst_b && !rstPin) // R8
        begin
            if (progMode && progDataDrive)
            begin
                firstIoPortOut = progDataOut; // R7
                firstIoPortOe_b = progDataOut; // R7
            end
            else if (!progMode)
                firstIoPortOe_b = firstLatch; // R2
            thirdIoPortOe_b = thirdLatch | ~THIRD_GPIO_MASK; // R3
            thirdIoPortOe_b[TXD_BIT] = thirdLatch[TXD_BIT] & serialTx; // R6
            if (progMode)
                thirdIoPortOe_b = 8'hff; // R7
        end
    end

    always_comb
    begin
        firstIoPortRead = firstPin & firstLatch; // R19
        thirdIoPortRead = thirdPin & thirdLatch;
        thirdIoPortRead[CMP_OUT_BIT] = cmpOut; // R4
    end

    assign comparatorPlusInput = firstPin[CMP_PLUS_BIT]; // R5
    assign comparatorMinusInput = firstPin[CMP_MINUS_BIT]; // R5
    assign serialRx = thirdPin[RXD_BIT]; // R6
    assign externalIrqZero = thirdPin[IRQ0_BIT]; // R6
    assign externalIrqOne = thirdPin[IRQ1_BIT]; // R6
    assign counterZeroInput = thirdPin[CNT0_BIT]; // R6
    assign counterOneInput = thirdPin[CNT1_BIT]; // R6
    assign progDataIn = firstPin; // R7
    assign progControl = thirdPin; // R7

    property p_resetHigh;
        @(posedge clk) rstPin |-> firstIoPortOe_b == 8'hff && thirdIoPortOe_b == 8'hff;
    endproperty
    a_resetHigh: assert property (p_resetHigh) else $error("pin driven during reset"); // R8

    property p_latchReload;
        @(posedge clk) disable iff (!rst_b) fullReset |=> firstLatch == 8'hff && thirdLatch == 8'hff;
    endproperty
    a_latchReload: assert property (p_latchReload) else $error("latch not reloaded"); // R18

    property p_inputRelease;
        @(posedge clk) disable iff (!rst_b)
        (firstLatch[3] && !rstPin && !progMode) |-> firstIoPortOe_b[3];
    endproperty
    a_inputRelease: assert property (p_inputRelease) else $error("drive not released"); // R2

    property p_cmpBit;
        @(posedge clk) disable iff (!rst_b) thirdIoPortRead[6] == cmpOut && thirdIoPortOe_b[6];
    endproperty
    a_cmpBit: assert property (p_cmpBit) else $error("bit six misused"); // R4

    property p_idleExit;
        @(posedge clk) disable iff (!rst_b) (pwr == PWR_IDLE && irqPending) |=> pwr == PWR_RUN;
    endproperty
    a_idleExit: assert property (p_idleExit) else $error("idle not left"); // R16

    property p_idleClocks;
        @(posedge clk) disable iff (!rst_b) pwr == PWR_IDLE |-> !cpuClkEn && periphClkEn;
    endproperty
    a_idleClocks: assert property (p_idleClocks) else $error("idle gating wrong"); // R14

    property p_downStay;
        @(posedge clk) disable iff (!rst_b) (pwr == PWR_DOWN && !fullReset) |=> pwr == PWR_DOWN;
    endproperty
    a_downStay: assert property (p_downStay) else $error("power-down left early"); // R15

    property p_ramBlock;
        @(posedge clk) disable iff (!rst_b) rstPin |-> !ramAccessEn;
    endproperty
    a_ramBlock: assert property (p_ramBlock) else $error("ram open during reset"); // R17

    c_idle: cover property (@(posedge clk) pwr == PWR_IDLE ##1 pwr == PWR_RUN);
    c_down: cover property (@(posedge clk) pwr == PWR_DOWN);
    c_full: cover property (@(posedge clk) fullReset);
endmodule
`default_nettype wire

// *** dv/port_reset_clock_control_tb.sv ***
// self-checking bench for the port, reset and clock sequencing block
// board model resolves pins; the bench plays the cpu and the programmer
`timescale 1ns/1ps
`default_nettype none
module port_reset_clock_control_tb;
    import prcc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] ext1Low = 8'h00, ext3Low = 8'h00, pin1, pin3, out1, oe1_b, out3, oe3_b;
    logic cmpOut = 1'b0, cpuFirstWrite = 1'b0, cpuThirdWrite = 1'b0, serialTx = 1'b1;
    logic [7:0] cpuWriteData = 8'hff, progDataOut = 8'h00, rd1, rd3, pIn, pCtl;
    logic progMode = 1'b0, progDataDrive = 1'b0, idleReq = 1'b0, powerDownReq = 1'b0;
    logic irqPending = 1'b0, cPlus, cMinus, rx, irq0, irq1, cnt0, cnt1;
    logic cpuClkEn, periphClkEn, halfClk, machineTick, h0, ramEn, fullRst;
    int error_cnt = 0, cmp_count = 0, n;
    initial forever #12.5 clk = ~clk;
    prcc_port_top i_prcc_port_top (.clk(clk), .rst_b(rst_b), .firstIoPortIn(pin1),
        .firstIoPortOut(out1), .firstIoPortOe_b(oe1_b), .thirdIoPortIn(pin3),
        .thirdIoPortOut(out3), .thirdIoPortOe_b(oe3_b), .cmpOut(cmpOut),
        .comparatorPlusInput(cPlus), .comparatorMinusInput(cMinus),
        .cpuFirstWrite(cpuFirstWrite), .cpuThirdWrite(cpuThirdWrite),
        .cpuWriteData(cpuWriteData), .firstIoPortRead(rd1), .thirdIoPortRead(rd3),
        .serialTx(serialTx), .serialRx(rx), .externalIrqZero(irq0), .externalIrqOne(irq1),
        .counterZeroInput(cnt0), .counterOneInput(cnt1), .progMode(progMode),
        .progDataDrive(progDataDrive), .progDataOut(progDataOut), .progDataIn(pIn),
        .progControl(pCtl), .idleReq(idleReq), .powerDownReq(powerDownReq),
        .irqPending(irqPending), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
        .ramAccessEn(ramEn), .fullReset(fullRst), .halfClk(halfClk),
        .machineTick(machineTick));
    prcc_board_model i_prcc_board_model (.out1(out1), .oe1_b(oe1_b), .out3(out3),
        .oe3_b(oe3_b), .ext1Low(ext1Low), .ext3Low(ext3Low), .pin1(pin1), .pin3(pin3));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic third, input logic [7:0] d);
        @(negedge clk);
        cpuFirstWrite = ~third;
        cpuThirdWrite = third;
        cpuWriteData = d;
        @(negedge clk);
        cpuFirstWrite = 1'b0;
        cpuThirdWrite = 1'b0;
    endtask
    // input path goes through a synchroniser, so give it margin
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask
    task automatic t_reset();
        wr(1'b0, 8'h00);
        wr(1'b1, 8'h00);
        #3 rst_b = 1'b0;
        #1 check("oe1 in reset", oe1_b, 8'hff);
        check("oe3 in reset", oe3_b, 8'hff);
        check("ram in reset", {7'h00, ramEn}, 8'h00);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        check("oe1 reloaded", oe1_b, 8'hff);
        check("oe3 reloaded", oe3_b, 8'hff);
    endtask
    task automatic t_first();
        wr(1'b0, 8'h5a);
        check("oe1 after write", oe1_b, 8'h5a);
        settle();
        check("first read", rd1, 8'h5a);
        check("cmp inputs", {6'h00, cMinus, cPlus}, 8'h02);
        check("ram open", {7'h00, ramEn}, 8'h01);
        wr(1'b0, 8'hff);
        ext1Low = 8'h3c;
        settle();
        check("oe1 released", oe1_b, 8'hff);
        check("first input read", rd1, 8'hc3);
        ext1Low = 8'h00;
    endtask
    task automatic t_third();
        wr(1'b1, 8'h00);
        check("oe3 bit6 kept", oe3_b, 8'h40);
        check("out3 sinks only", out3, 8'h00);
        cmpOut = 1'b1;
        settle();
        check("third read cmp 1", rd3, 8'h40);
        cmpOut = 1'b0;
        settle();
        check("third read cmp 0", rd3, 8'h00);
        wr(1'b1, 8'hff);
        ext3Low = 8'h15;
        serialTx = 1'b0;
        settle();
        check("alt inputs", {3'h0, cnt1, cnt0, irq1, irq0, rx}, 8'h14);
        check("tx pulls pin", {7'h00, oe3_b[1]}, 8'h00);
        serialTx = 1'b1;
        ext3Low = 8'h00;
    endtask
    task automatic t_prog();
        progMode = 1'b1;
        ext1Low = 8'h0f;
        ext3Low = 8'h81;
        settle();
        check("prog data in", pIn, 8'hf0);
        check("prog control", pCtl, 8'h7e);
        ext1Low = 8'h00;
        progDataOut = 8'ha5;
        progDataDrive = 1'b1;
        settle();
        check("prog data out", oe1_b, 8'ha5);
        check("prog out value", out1, 8'ha5);
        progDataDrive = 1'b0;
        progMode = 1'b0;
        ext3Low = 8'h00;
        settle();
    endtask
    task automatic t_clock();
        n = 0;
        repeat (120)
        begin
            @(negedge clk);
            if (machineTick === 1'b1)
                n++;
        end
        check("ticks in 120", 8'(n), 8'h0a);
        h0 = halfClk;
        @(negedge clk);
        check("half toggles", {7'h00, halfClk}, {7'h00, ~h0});
    endtask
    task automatic t_power();
        @(negedge clk);
        idleReq = 1'b1;
        @(negedge clk);
        idleReq = 1'b0;
        check("idle cpu clk", {6'h00, cpuClkEn, periphClkEn}, 8'h01);
        repeat (3) @(negedge clk);
        irqPending = 1'b1;
        @(negedge clk);
        irqPending = 1'b0;
        check("irq wakes", {7'h00, cpuClkEn}, 8'h01);
        powerDownReq = 1'b1;
        @(negedge clk);
        powerDownReq = 1'b0;
        @(negedge clk);
        h0 = halfClk;
        repeat (4) @(negedge clk);
        check("pd frozen", {6'h00, periphClkEn, halfClk}, {7'h00, h0});
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        check("reset exits pd", {6'h00, cpuClkEn, periphClkEn}, 8'h03);
        check("short reset not full", {7'h00, fullRst}, 8'h00);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_reset();
        t_first();
        t_third();
        t_prog();
        t_clock();
        t_power();
        complete_run();
    end
    initial
    begin
        #(25 * 2000);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire

// *** dv/prcc_board_model.sv ***
// board model: pullups on every port pin plus optional external pull-downs
// assumes the design only ever sinks a pin, never drives it high
`timescale 1ns/1ps
`default_nettype none
module prcc_board_model
(
    input wire logic [7:0] out1, // first port drive value
    input wire logic [7:0] oe1_b, // first port enable, low drives
    input wire logic [7:0] out3, // third port drive value
    input wire logic [7:0] oe3_b, // third port enable, low drives
    input wire logic [7:0] ext1Low, // board pulls first pins low
    input wire logic [7:0] ext3Low, // board pulls third pins low
    output logic [7:0] pin1, // resolved first port pins
    output logic [7:0] pin3 // resolved third port pins
);
    // released pins float to the pullup, so no stale level survives
    assign pin1 = (~oe1_b & out1) | (oe1_b & ~ext1Low);
    assign pin3 = (~oe3_b & out3) | (oe3_b & ~ext3Low);
endmodule
`default_nettype wire
